/* bcce_pkg.sv */
// constants, types and register map of the bounds/compare/clear executor
`default_nettype none
package bcce_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_OPCODE = 8'h04;
  localparam logic [7:0] ADDR_EXT    = 8'h08;
  localparam logic [7:0] ADDR_REGVAL = 8'h0c;
  localparam logic [7:0] ADDR_SRC    = 8'h10;
  localparam logic [7:0] ADDR_EA     = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_RESULT = 8'h1c;
  localparam logic [7:0] ADDR_CCR    = 8'h20;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_GO    = 0;
  localparam int CTRL_CLR   = 1;
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_ILLEGAL = 2;
  localparam int ST_TRAP    = 3;
  localparam int CCR_C      = 0;
  localparam int CCR_V      = 1;
  localparam int CCR_Z      = 2;
  localparam int CCR_N      = 3;
  localparam int CCR_X      = 4;
  localparam logic [4:0]  CCR_RESET  = 5'h00;
  localparam logic [7:0]  CHK_VECTOR = 8'h06;
  localparam logic [11:0] EXT2_FIXED = 12'h800;
  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] SZ_BYTE  = 2'h0;
  localparam logic [1:0] SZ_WORD  = 2'h1;
  localparam logic [1:0] SZ_LONG  = 2'h2;
  localparam logic [1:0] CHK_WORD = 2'h3;
  localparam logic [1:0] CHK_LONG = 2'h2;
  localparam logic [2:0] M_DREG   = 3'h0;
  localparam logic [2:0] M_AREG   = 3'h1;
  localparam logic [2:0] M_IND    = 3'h2;
  localparam logic [2:0] M_DISP   = 3'h5;
  localparam logic [2:0] M_INDEX  = 3'h6;
  localparam logic [2:0] M_EXT    = 3'h7;
  localparam logic [2:0] R_IMM    = 3'h4;
  localparam logic [2:0] OPM_LONG = 3'h2;
  localparam logic [3:0] TOP_CMP  = 4'hb;
  localparam logic [3:0] TOP_CHK  = 4'h4;
  localparam logic [7:0] TOP_CLR  = 8'h42;
  localparam logic [2:0] TWO_BOUND_CHECK_MID = 3'h3;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_RD_LO, S_RD_HI, S_WR, S_EXEC} state_t;
  typedef enum logic [2:0] {I_NONE, I_CHK, I_TWO_BOUND_CHECK, I_CLR, I_CMP} instr_t;
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [1:0]  size;
    logic [31:0] wdata;
  } memReq_t;
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } memRsp_t;
endpackage
`default_nettype wire

/* bounds_check_compare_clear_exec.sv */
// executor for bound checks, clear-operand and compare-to-data-register
// Function
// - single bound check takes data modes only, not address reg; imm 111/100
// - two bound check reads lower bound first, then upper right after
// - two bound size 00 byte, 01 word, 10 long
// - data register at byte/word compares only its low part
// - address reg at byte/word sign-extends bounds, compares full register
// - value below lower or above upper bound traps with vector 6
// - equal bounds accept exactly that one value
// - Z set when value equals a bound; X kept; N, V undefined
// - C set when out of bounds, cleared when in range
// - extension kind bit 0 data, 1 address; next field names register
// - two bound check takes control modes only
// - clear writes zero; N V C cleared, Z set, X kept
// - clear sizes 00/01/10; data alterable destinations only
// - compare subtracts source from data register, register unchanged
// - compare sets N Z V C from result; X kept
// - compare opmode 000 byte, 001 word, 010 long
// - compare takes every mode; address register only at word and long
// - single bound check traps on negative or above bound; 11 word 10 long
//
// Our own choices: the register addresses and the Wishbone register port.
`default_nettype none
module bounds_check_compare_clear_exec (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // operand memory port
  output bcce_pkg::memReq_t      memReq,
  input  wire bcce_pkg::memRsp_t memRsp,
  // exception request
  output logic                   trapReq,
  output logic      [7:0]        trapVector
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // left-justify an operand so one 32-bit compare serves every size
  function automatic logic [31:0] align(logic [31:0] x, logic [1:0] sz);
    unique case (sz)
      bcce_pkg::SZ_BYTE: align = {x[7:0], 24'h000000};
      bcce_pkg::SZ_WORD: align = {x[15:0], 16'h0000};
      default:           align = x;
    endcase
  endfunction
  function automatic logic [31:0] sext(logic [31:0] x, logic [1:0] sz);
    unique case (sz)
      bcce_pkg::SZ_BYTE: sext = {{24{x[7]}}, x[7:0]};
      bcce_pkg::SZ_WORD: sext = {{16{x[15]}}, x[15:0]};
      default:           sext = x;
    endcase
  endfunction
  function automatic logic [31:0] wmerge(logic [31:0] old, d,
                                         logic [3:0] s);
    wmerge = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) wmerge[8*i +: 8] = d[8*i +: 8];
    end
  endfunction
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  bcce_pkg::state_t  state_q, state_d;
  bcce_pkg::instr_t  ins_q, ins_d, insDec;
  bcce_pkg::memReq_t mem_q, mem_d;
  logic [15:0] opcode_q, opcode_d, ext_q, ext_d;
  logic [31:0] regVal_q, regVal_d, src_q, src_d, ea_q, ea_d;
  logic [31:0] result_q, result_d, lo_q, lo_d, hi_q, hi_d;
  logic [31:0] datR_q, datR_d;
  logic [4:0]  ccr_q, ccr_d;
  logic [1:0]  size_q, size_d, sizeDec;
  logic        ack_q, ack_d, done_q, done_d, illegal_q, illegal_d;
  logic        trap_q, trap_d, trapReq_q, trapReq_d;
  // ---------------------------------------------------------------
  // decode of the loaded opcode and extension word
  // ---------------------------------------------------------------
  logic [2:0] eaMode, eaReg;
  logic       dataMode, ctlMode, altMode, go, clrDone, busAcc;
  assign eaMode = opcode_q[5:3];
  assign eaReg  = opcode_q[2:0];
  assign busAcc = cyc_i && stb_i && !ack_q;
  assign go      = busAcc && we_i && sel_i[0] &&
                   adr_i == bcce_pkg::ADDR_CTRL && dat_i[bcce_pkg::CTRL_GO];
  assign clrDone = busAcc && we_i && sel_i[0] &&
                   adr_i == bcce_pkg::ADDR_CTRL && dat_i[bcce_pkg::CTRL_CLR];
  // addressing-mode classes
  always_comb begin
    dataMode = eaMode != bcce_pkg::M_AREG &&
               !(eaMode == bcce_pkg::M_EXT && eaReg > bcce_pkg::R_IMM);
    ctlMode  = eaMode == bcce_pkg::M_IND || eaMode == bcce_pkg::M_DISP ||
               eaMode == bcce_pkg::M_INDEX ||
               (eaMode == bcce_pkg::M_EXT && !eaReg[2]);
    altMode  = eaMode != bcce_pkg::M_AREG &&
               !(eaMode == bcce_pkg::M_EXT && eaReg[2:1] != 2'h0);
  end
  // instruction recognition and operand size
  always_comb begin
    insDec  = bcce_pkg::I_NONE;
    sizeDec = bcce_pkg::SZ_LONG;
    if (opcode_q[15:12] == bcce_pkg::TOP_CHK && !opcode_q[6] &&
        opcode_q[8] && dataMode) begin
      insDec  = bcce_pkg::I_CHK;
      sizeDec = (opcode_q[8:7] == bcce_pkg::CHK_WORD) ?
                bcce_pkg::SZ_WORD : bcce_pkg::SZ_LONG;
    end else if (opcode_q[15:11] == 5'h00 &&
                 opcode_q[8:6] == bcce_pkg::TWO_BOUND_CHECK_MID &&
                 opcode_q[10:9] != 2'h3 && ctlMode &&
                 ext_q[11:0] == bcce_pkg::EXT2_FIXED) begin
      insDec  = bcce_pkg::I_TWO_BOUND_CHECK;
      sizeDec = opcode_q[10:9];
    end else if (opcode_q[15:8] == bcce_pkg::TOP_CLR &&
                 opcode_q[7:6] != 2'h3 && altMode) begin
      insDec  = bcce_pkg::I_CLR;
      sizeDec = opcode_q[7:6];
    end else if (opcode_q[15:12] == bcce_pkg::TOP_CMP &&
                 opcode_q[8:6] <= bcce_pkg::OPM_LONG &&
                 !(eaMode == bcce_pkg::M_AREG &&
                   opcode_q[7:6] == bcce_pkg::SZ_BYTE)) begin
      insDec  = bcce_pkg::I_CMP;
      sizeDec = opcode_q[7:6];
    end
  end
  // ---------------------------------------------------------------
  // arithmetic of the execute step
  // ---------------------------------------------------------------
  logic [31:0] val, lb, ub, cmpD, cmpS, diff, bytes;
  logic        outRange, eqLo, eqHi, chkNeg, chkGt;
  always_comb begin
    bytes = 32'h1 << size_q;
    if (ext_q[15] && size_q != bcce_pkg::SZ_LONG) begin
      val = regVal_q;
      lb  = sext(lo_q, size_q);
      ub  = sext(hi_q, size_q);
    end else begin
      val = align(regVal_q, size_q);
      lb  = align(lo_q, size_q);
      ub  = align(hi_q, size_q);
    end
    // distance above the lower bound works for signed and unsigned pairs
    outRange = (val - lb) > (ub - lb);
    eqLo     = val == lb;
    eqHi     = val == ub;
    cmpD     = align(regVal_q, size_q);
    cmpS     = align(src_q, size_q);
    diff     = cmpD - cmpS;
    chkNeg   = cmpD[31];
    chkGt    = $signed(cmpD) > $signed(cmpS);
  end
  // ---------------------------------------------------------------
  // next-state logic: bus slave, sequencer and execute
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;   ins_d = ins_q;       mem_d = mem_q;
    opcode_d = opcode_q; ext_d = ext_q;       regVal_d = regVal_q;
    src_d = src_q;       ea_d = ea_q;         result_d = result_q;
    lo_d = lo_q;         hi_d = hi_q;         ccr_d = ccr_q;
    size_d = size_q;     done_d = done_q;     illegal_d = illegal_q;
    trap_d = trap_q;     trapReq_d = 1'b0;    datR_d = datR_q;
    ack_d = busAcc;
    // register writes and reads, one wait state
    if (busAcc && we_i) begin
      unique case (adr_i)
        bcce_pkg::ADDR_OPCODE: opcode_d = 16'(wmerge({16'h0, opcode_q},
                                          dat_i, sel_i));
        bcce_pkg::ADDR_EXT:    ext_d = 16'(wmerge({16'h0, ext_q},
                                          dat_i, sel_i));
        bcce_pkg::ADDR_REGVAL: regVal_d = wmerge(regVal_q, dat_i, sel_i);
        bcce_pkg::ADDR_SRC:    src_d = wmerge(src_q, dat_i, sel_i);
        bcce_pkg::ADDR_EA:     ea_d = wmerge(ea_q, dat_i, sel_i);
        bcce_pkg::ADDR_CCR:    if (sel_i[0]) ccr_d = dat_i[4:0];
        default: ;
      endcase
    end
    if (busAcc && !we_i) begin
      unique case (adr_i)
        bcce_pkg::ADDR_OPCODE: datR_d = {16'h0, opcode_q};
        bcce_pkg::ADDR_EXT:    datR_d = {16'h0, ext_q};
        bcce_pkg::ADDR_REGVAL: datR_d = regVal_q;
        bcce_pkg::ADDR_SRC:    datR_d = src_q;
        bcce_pkg::ADDR_EA:     datR_d = ea_q;
        bcce_pkg::ADDR_RESULT: datR_d = result_q;
        bcce_pkg::ADDR_CCR:    datR_d = {27'h0, ccr_q};
        bcce_pkg::ADDR_STATUS: datR_d = {8'h0,
                                 trap_q ? bcce_pkg::CHK_VECTOR : 8'h00,
                                 12'h0, trap_q, illegal_q, done_q,
                                 state_q != bcce_pkg::S_IDLE};
        default:               datR_d = 32'h0;
      endcase
    end
    if (clrDone) done_d = 1'b0;
    // sequencer; a finishing instruction sets done over a clear
    unique case (state_q)
      bcce_pkg::S_IDLE: if (go) begin
        ins_d = insDec;  size_d = sizeDec;
        trap_d = 1'b0;   illegal_d = 1'b0;  done_d = 1'b0;
        mem_d = '0;      mem_d.addr = ea_q; mem_d.size = sizeDec;
        if (insDec == bcce_pkg::I_NONE) begin
          illegal_d = 1'b1;
          done_d    = 1'b1;
        end else if (insDec == bcce_pkg::I_TWO_BOUND_CHECK) begin
          mem_d.req = 1'b1;
          state_d   = bcce_pkg::S_RD_LO;
        end else if (insDec == bcce_pkg::I_CLR &&
                     eaMode != bcce_pkg::M_DREG) begin
          mem_d.req = 1'b1;
          mem_d.we  = 1'b1;
          state_d   = bcce_pkg::S_WR;
        end else begin
          state_d = bcce_pkg::S_EXEC;
        end
      end
      bcce_pkg::S_RD_LO: if (memRsp.ack) begin
        lo_d       = memRsp.rdata;
        mem_d.addr = mem_q.addr + bytes;
        state_d    = bcce_pkg::S_RD_HI;
      end
      bcce_pkg::S_RD_HI: if (memRsp.ack) begin
        hi_d      = memRsp.rdata;
        mem_d.req = 1'b0;
        state_d   = bcce_pkg::S_EXEC;
      end
      bcce_pkg::S_WR: if (memRsp.ack) begin
        mem_d     = '0;
        state_d   = bcce_pkg::S_EXEC;
      end
      bcce_pkg::S_EXEC: begin
        state_d = bcce_pkg::S_IDLE;
        done_d  = 1'b1;
        unique case (ins_q)
          bcce_pkg::I_CHK: begin
            if (chkNeg) ccr_d[bcce_pkg::CCR_N] = 1'b1;
            else if (chkGt) ccr_d[bcce_pkg::CCR_N] = 1'b0;
            trap_d = chkNeg || chkGt;
          end
          bcce_pkg::I_TWO_BOUND_CHECK: begin
            ccr_d[bcce_pkg::CCR_Z] = eqLo || eqHi;
            ccr_d[bcce_pkg::CCR_C] = outRange;
            trap_d = outRange;
          end
          bcce_pkg::I_CLR: begin
            ccr_d[3:0] = 4'h4;
            unique case (size_q)
              bcce_pkg::SZ_BYTE: result_d = {regVal_q[31:8], 8'h00};
              bcce_pkg::SZ_WORD: result_d = {regVal_q[31:16], 16'h0000};
              default:           result_d = 32'h0;
            endcase
          end
          default: begin
            ccr_d[bcce_pkg::CCR_N] = diff[31];
            ccr_d[bcce_pkg::CCR_Z] = diff == 32'h0;
            ccr_d[bcce_pkg::CCR_V] = (cmpD[31] != cmpS[31]) &&
                                     (diff[31] != cmpD[31]);
            ccr_d[bcce_pkg::CCR_C] = cmpS > cmpD;
          end
        endcase
        trapReq_d = trap_d;
      end
      default: state_d = bcce_pkg::S_IDLE;
    endcase
  end
  // registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= bcce_pkg::S_IDLE;  ins_q <= bcce_pkg::I_NONE;
      mem_q <= '0;       opcode_q <= 16'h0;  ext_q <= 16'h0;
      regVal_q <= 32'h0; src_q <= 32'h0;     ea_q <= 32'h0;
      result_q <= 32'h0; lo_q <= 32'h0;      hi_q <= 32'h0;
      datR_q <= 32'h0;   ccr_q <= bcce_pkg::CCR_RESET;
      size_q <= bcce_pkg::SZ_BYTE;  ack_q <= 1'b0;  done_q <= 1'b0;
      illegal_q <= 1'b0; trap_q <= 1'b0;     trapReq_q <= 1'b0;
    end else begin
      state_q <= state_d;   ins_q <= ins_d;       mem_q <= mem_d;
      opcode_q <= opcode_d; ext_q <= ext_d;       regVal_q <= regVal_d;
      src_q <= src_d;       ea_q <= ea_d;         result_q <= result_d;
      lo_q <= lo_d;         hi_q <= hi_d;         datR_q <= datR_d;
      ccr_q <= ccr_d;       size_q <= size_d;     ack_q <= ack_d;
      done_q <= done_d;     illegal_q <= illegal_d;
      trap_q <= trap_d;     trapReq_q <= trapReq_d;
    end
  end
  assign dat_o      = datR_q;
  assign ack_o      = ack_q;
  assign memReq     = mem_q;
  assign trapReq    = trapReq_q;
  assign trapVector = bcce_pkg::CHK_VECTOR;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic isExec;
  assign isExec = state_q == bcce_pkg::S_EXEC;
  AST_ACK_ONE: assert property (ack_o |=> !ack_o)
    else $error("ack held two cycles");
  AST_CHK_AREG: assert property (go && state_q == bcce_pkg::S_IDLE &&
      opcode_q[15:12] == bcce_pkg::TOP_CHK && opcode_q[8] &&
      !opcode_q[6] && eaMode == bcce_pkg::M_AREG |=> illegal_q)
    else $error("address register bound accepted");
  AST_LO_FIRST: assert property (state_q == bcce_pkg::S_RD_LO &&
      memRsp.ack |=> state_q == bcce_pkg::S_RD_HI &&
      memReq.addr == $past(memReq.addr) + bytes && memReq.req)
    else $error("upper bound not fetched after lower");
  AST_TWO_BOUND_CHECK_C: assert property (isExec && ins_q == bcce_pkg::I_TWO_BOUND_CHECK
      |=> ccr_q[bcce_pkg::CCR_C] == trap_q &&
          ccr_q[bcce_pkg::CCR_X] == $past(ccr_q[bcce_pkg::CCR_X]))
    else $error("carry does not follow range result");
  AST_EQ_BOUNDS: assert property (isExec && ins_q == bcce_pkg::I_TWO_BOUND_CHECK
      && lb == ub && val == lb |=> !trap_q && ccr_q[bcce_pkg::CCR_Z])
    else $error("single-value range trapped");
  AST_TRAP_VEC: assert property (isExec && ins_q == bcce_pkg::I_TWO_BOUND_CHECK
      && outRange |=> trapReq && trapVector == 8'h06 ##1 !trapReq)
    else $error("missing vector 6 trap");
  AST_CLR_FLAGS: assert property (isExec && ins_q == bcce_pkg::I_CLR
      |=> ccr_q[3:0] == 4'h4 && done_q)
    else $error("clear flags wrong");
  AST_CMP_Z: assert property (isExec && ins_q == bcce_pkg::I_CMP
      |=> ccr_q[bcce_pkg::CCR_Z] == ($past(cmpD) == $past(cmpS)) &&
          regVal_q == $past(regVal_q))
    else $error("compare zero flag wrong");
  AST_CMP_BYTE_AREG: assert property (go &&
      state_q == bcce_pkg::S_IDLE && opcode_q[15:12] == bcce_pkg::TOP_CMP
      && opcode_q[8:6] == 3'h0 && eaMode == bcce_pkg::M_AREG
      |=> illegal_q && state_q == bcce_pkg::S_IDLE)
    else $error("byte compare from address register accepted");
  COV_TWO_BOUND_CHECK_TRAP: cover property (isExec && ins_q == bcce_pkg::I_TWO_BOUND_CHECK &&
      outRange);
  COV_CMP: cover property (isExec && ins_q == bcce_pkg::I_CMP);
  COV_CLR_MEM: cover property (state_q == bcce_pkg::S_WR && memRsp.ack);
endmodule
`default_nettype wire

/* operand_mem_model.sv */
// operand memory model facing the executor's memory port
`default_nettype none
module operand_mem_model (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // answer latency in cycles
  input  wire logic [3:0]        waitCycles,
  // memory port
  input  wire bcce_pkg::memReq_t memReq,
  output var  bcce_pkg::memRsp_t memRsp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [256];
  logic [31:0] rdAddr [$];
  logic [3:0]  cnt;
  // bytes moved by a transfer of the given size
  function automatic int nb(input logic [1:0] sz);
    return (sz == 2'h0) ? 1 : (sz == 2'h1) ? 2 : 4;
  endfunction
  // -------------------------------------------------------------
  // one answer per request; idle data toggles so it never matches
  // -------------------------------------------------------------
  always @(posedge clk) begin : answer
    int n;
    logic [31:0] r;
    n = nb(memReq.size);
    r = '0;
    memRsp.ack   <= 1'b0;
    memRsp.rdata <= ~memRsp.rdata;
    if (!rst_b) begin
      memRsp <= '0;
      cnt    <= '0;
    end else if (memReq.req && !memRsp.ack) begin
      if (cnt != waitCycles) begin
        cnt <= cnt + 4'h1;
      end else begin
        cnt        <= '0;
        memRsp.ack <= 1'b1;
        for (int i = 0; i < n; i++) begin
          r = {r[23:0], mem[8'(memReq.addr[7:0] + i)]};
          if (memReq.we)
            mem[8'(memReq.addr[7:0] + i)] <=
              8'(memReq.wdata >> (8 * (n - 1 - i)));
        end
        if (!memReq.we) begin
          memRsp.rdata <= r; // big-endian, right-justified
          rdAddr.push_back(memReq.addr);
        end
      end
    end
  end
endmodule
`default_nettype wire

/* tb.sv */
// self-checking bench for the bounds, compare and clear executor
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk;
  logic              rst_b;
  logic              cyc;
  logic              stb;
  logic              we;
  logic [7:0]        adr;
  logic [3:0]        sel;
  logic [31:0]       wdat;
  logic [31:0]       rdat;
  logic              ack;
  logic              trapReq;
  logic [7:0]        trapVector;
  logic [3:0]        waitCycles;
  bcce_pkg::memReq_t memReq;
  bcce_pkg::memRsp_t memRsp;
  logic [31:0]       q;
  logic [7:0]        badClr [3] = '{8'h88, 8'hbc, 8'hba};
  int                errTotal;
  int                checkCount;
  int                trapCount;
  int                cycles;
  bounds_check_compare_clear_exec dut_u (
    .clk(clk), .rst_b(rst_b), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .memReq(memReq), .memRsp(memRsp), .trapReq(trapReq),
    .trapVector(trapVector));
  operand_mem_model mu (
    .clk(clk), .rst_b(rst_b), .waitCycles(waitCycles),
    .memReq(memReq), .memRsp(memRsp));
  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // cycle ceiling and trap pulse count
  always @(posedge clk) begin
    cycles++;
    if (trapReq === 1'b1) trapCount++;
    if (cycles == 6000) begin
      errTotal++;
      print_verdict();
    end
  end
  // --------------------------------------------------------------
  // bus tasks and comparison
  // --------------------------------------------------------------
  task automatic print_verdict();
    if (errTotal == 0 && checkCount > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checkCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // classic cycle: hold until ack is sampled, then release one cycle
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // load operands, start, wait for done, compare status and flags
  task automatic op(input logic [15:0] o, x, input logic [31:0] rv, s,
                    ea, input logic [4:0] m, ce, input logic il, tr);
    int t0;
    int n;
    mu.rdAddr.delete();
    wb(1'b1, bcce_pkg::ADDR_CCR, 32'h1f);
    wb(1'b1, bcce_pkg::ADDR_OPCODE, {16'h0, o});
    wb(1'b1, bcce_pkg::ADDR_EXT, {16'h0, x});
    wb(1'b1, bcce_pkg::ADDR_REGVAL, rv);
    wb(1'b1, bcce_pkg::ADDR_SRC, s);
    wb(1'b1, bcce_pkg::ADDR_EA, ea);
    wb(1'b1, bcce_pkg::ADDR_CTRL, 32'h2);
    t0 = trapCount;
    n = 0;
    wb(1'b1, bcce_pkg::ADDR_CTRL, 32'h1);
    do begin
      wb(1'b0, bcce_pkg::ADDR_STATUS, '0);
      n++;
    end while (q[1] !== 1'b1 && n < 50);
    check("status", 32'(q[3:0]), 32'({tr, il, 2'b10}));
    if (tr) check("vector", {q[23:16], trapVector}, 32'h0606);
    check("pulse", 32'(trapCount - t0), 32'(tr));
    wb(1'b0, bcce_pkg::ADDR_CCR, '0);
    check("ccr", 32'(q[4:0] & m), 32'(ce));
  endtask
  task automatic reads(input logic [31:0] a0, a1);
    check("rd0", mu.rdAddr[0], a0);
    check("rd1", mu.rdAddr[1], a1);
  endtask
  task automatic put(input int a, n, input logic [31:0] v);
    for (int i = 0; i < n; i++) mu.mem[a + i] = 8'(v >> (8 * (n - 1 - i)));
  endtask
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = 4'hf;
    wdat = '0;
    waitCycles = '0;
    put(16, 2, 32'h1020);
    put(32, 4, 32'hfff00010);
    put(48, 4, 32'h100);
    put(52, 4, 32'h100);
    put(64, 4, 32'haaaaaaaa);
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    wb(1'b0, bcce_pkg::ADDR_STATUS, '0);
    check("st0", q, '0);
    wb(1'b0, bcce_pkg::ADDR_CCR, '0);
    check("ccr0", q, '0);
    wb(1'b0, 8'hfc, '0);
    check("unmapped", q, '0);
    op(16'hb080, 0, 5, 7, 0, 5'h1f, 5'h19, 0, 0);
    wb(1'b0, bcce_pkg::ADDR_REGVAL, '0);
    check("keep", q, 32'h5);
    op(16'hb048, 0, 32'h12348000, 1, 0, 5'h1f, 5'h12, 0, 0);
    op(16'hb000, 0, 32'hffffff42, 32'h42, 0, 5'h1f, 5'h14, 0, 0);
    op(16'hb008, 0, 0, 0, 0, 5'h1f, 5'h1f, 1, 0);
    op(16'hb0c0, 0, 0, 0, 0, 5'h1f, 5'h1f, 1, 0);
    for (int s = 0; s < 3; s++) begin
      op({8'h42, 2'(s), 6'h0}, 0, '1, 0, 0, 5'h1f, 5'h14, 0, 0);
      wb(1'b0, bcce_pkg::ADDR_RESULT, '0);
      check("clrRes", q, ~((32'h1 << (8 << s)) - 1));
    end
    op(16'h4290, 0, 0, 0, 32'h40, 5'h1f, 5'h14, 0, 0);
    check("clrMem", {mu.mem[64], mu.mem[65], mu.mem[66], mu.mem[67]},
          0);
    foreach (badClr[i])
      op({8'h42, badClr[i]}, 0, 0, 0, 0, 5'h1f, 5'h1f, 1, 0);
    op(16'h00d0, 16'h0800, 32'habcdef20, 0, 32'h10,
       5'h15, 5'h14, 0, 0);
    reads(32'h10, 32'h11);
    op(16'h02d0, 16'h9800, 32'hfffffff8, 0, 32'h20,
       5'h15, 5'h10, 0, 0);
    reads(32'h20, 32'h22);
    op(16'h02d0, 16'h9800, 32'hffffffe0, 0, 32'h20,
       5'h15, 5'h11, 0, 1);
    waitCycles <= 4'h3;
    op(16'h04d0, 16'h0800, 32'h101, 0, 32'h30,
       5'h15, 5'h11, 0, 1);
    reads(32'h30, 32'h34);
    op(16'h04f8, 16'h0800, 32'h100, 0, 32'h30,
       5'h15, 5'h14, 0, 0);
    waitCycles <= 4'h0;
    op(16'h04d0, 16'h0c00, 0, 0, 32'h30, 5'h1f, 5'h1f, 1, 0);
    op(16'h04d8, 16'h0800, 0, 0, 32'h30, 5'h1f, 5'h1f, 1, 0);
    op(16'h4180, 0, 32'h0000ffff, 5, 0, 5'h18, 5'h18, 0, 1);
    op(16'h4180, 0, 32'hffff0003, 5, 0, 5'h10, 5'h10, 0, 0);
    op(16'h413c, 0, 6, 5, 0, 5'h18, 5'h10, 0, 1);
    op(16'h413c, 0, 5, 5, 0, 5'h10, 5'h10, 0, 0);
    op(16'h4108, 0, 0, 0, 0, 5'h1f, 5'h1f, 1, 0);
    print_verdict();
  end
endmodule
`default_nettype wire
